// file: core/dds_serial_pkg.sv
/*
 Package for the serial write port of the synthesizer: word layout,
 decode codes and the carrier struct of a received word.
 Assumes nothing of its surroundings.
*/
package dds_serial_pkg;
   // ---------------------------------------------------------------
   // Word layout
   // ---------------------------------------------------------------
   localparam int WORD_BITS = 16;
   localparam int CTRL_MSB = 15;
   localparam int CTRL_LSB = 12;
   localparam int ADDR_MSB = 11;
   localparam int ADDR_LSB = 8;
   localparam int DATA_MSB = 7;
   localparam int PHASE_SEL_POS = 13;
   localparam int PHASE_MSB = 11;
   localparam logic [1:0] PHASE_CODE = 2'h3;
   localparam logic [11:0] PHASE_RESET = 12'h000;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   // Host shift clock ceiling, kept for reference by the bench
   localparam int SCLK_MAX_MHZ = 40;

   // Received word split by position
   typedef struct packed {
      logic [3:0] ctrl;
      logic [3:0] addr;
      logic [7:0] data;
   } serial_word_t;
endpackage : dds_serial_pkg

// file: core/dds_serial_write_port.sv
/*
 Write-only three-wire serial port with phase and frequency selection.
 Assumes the host drives the shift clock (link clock domain), the frame
 sync and the data; the system side runs on sys_clk_in.
*/
// Functional notes
// - Continuous or idling shift clock both accepted
// - Sample data on falling shift clock edge
// - Words arrive most significant bit first
// - Split word: control, address, data fields
// - Frequency select input picks frequency register
// - Two run-time selectable phase registers
// - Top bits 11 load phase register
`timescale 1ns/1ps
`default_nettype none
module dds_serial_write_port
   import dds_serial_pkg::*;
#(
   parameter int WORD_W = WORD_BITS
)
(
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire logic shift_clk_in,
   input wire logic frame_sync_n_in,
   input wire logic serial_data_in,
   input wire logic freq_reg_choose_in,
   input wire logic phase_reg_choose_in,
   output logic word_valid_out,
   output serial_word_t word_out,
   output logic [11:0] phase0_out,
   output logic [11:0] phase1_out,
   output logic freq_sel_out,
   output logic phase_sel_out
);
   // ---------------------------------------------------------------
   // Parameter check
   // ---------------------------------------------------------------
   // The shift counter and the field split serve one word width only;
   // a wider word would need a wider counter and a new field map.
   generate
      if (WORD_W != WORD_BITS) begin : g_bad_width
         $error("word width not supported");
      end
   endgenerate

   // ---------------------------------------------------------------
   // Decode helpers
   // ---------------------------------------------------------------
   // Phase words carry the phase code in the top two bits; used by the
   // load logic and by the checks, so it lives in one place.
   function automatic logic is_phase_word(input logic [15:0] w);
      return w[CTRL_MSB -: 2] == PHASE_CODE;
   endfunction

   // ---------------------------------------------------------------
   // Link domain: shift in on falling shift clock
   // ---------------------------------------------------------------
   logic [14:0] shreg;
   logic [3:0] bit_cnt;
   logic [15:0] link_word;
   logic link_toggle;

   // Count and shift; frame sync high clears the count so a short frame
   // never completes. The count has no reset of its own, the frame sync is it.
   always_ff @(negedge shift_clk_in or posedge frame_sync_n_in) begin
      if (frame_sync_n_in) begin
         bit_cnt <= 4'h0;
      end else begin
         bit_cnt <= bit_cnt + 4'h1;
      end
   end

   // Data sampled on the falling edge, first bit lands on top
   always_ff @(negedge shift_clk_in) begin
      if (!frame_sync_n_in) begin
         shreg <= {shreg[13:0], serial_data_in};
      end
   end

   // Capture word on the sixteenth edge only; a short frame never gets
   // here because the frame sync clears the count first.
   always_ff @(negedge shift_clk_in) begin
      if (!frame_sync_n_in && bit_cnt == 4'hF) begin
         link_word <= {shreg, serial_data_in};
      end
   end

   // Toggle flags each complete word to the system side. It is cleared
   // by the system reset so that it starts at a known level and the
   // synchroniser sees no false edge. Limitation: the host must keep the
   // shift clock still while reset is low, since release is not aligned
   // to the link clock.
   always_ff @(negedge shift_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         link_toggle <= 1'b0;
      end else if (!frame_sync_n_in && bit_cnt == 4'hF) begin
         link_toggle <= ~link_toggle;
      end
   end

   // ---------------------------------------------------------------
   // Crossing into the system domain (toggle plus held word)
   // ---------------------------------------------------------------
   logic [2:0] tog_sync;
   logic new_word;

   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         tog_sync <= 3'h0;
      end else begin
         tog_sync <= {tog_sync[1:0], link_toggle};
      end
   end
   // Word is stable for many system clocks once the toggle arrives
   assign new_word = tog_sync[2] ^ tog_sync[1];

   // ---------------------------------------------------------------
   // Word decode and register load
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         word_out <= serial_word_t'(WORD_RESET);
         word_valid_out <= 1'b0;
      end else begin
         word_valid_out <= new_word;
         if (new_word) begin
            word_out <= serial_word_t'(link_word);
         end
      end
   end

   // Phase registers loaded from words with top bits 11
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         phase0_out <= PHASE_RESET;
         phase1_out <= PHASE_RESET;
      end else if (new_word && is_phase_word(link_word)) begin
         if (link_word[PHASE_SEL_POS]) begin
            phase1_out <= link_word[PHASE_MSB:0];
         end else begin
            phase0_out <= link_word[PHASE_MSB:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // Select pins: asynchronous, two flip-flops each
   // ---------------------------------------------------------------
   logic [1:0] fsel_sync;
   logic [1:0] psel_sync;

   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         fsel_sync <= 2'h0;
         psel_sync <= 2'h0;
      end else begin
         fsel_sync <= {fsel_sync[0], freq_reg_choose_in};
         psel_sync <= {psel_sync[0], phase_reg_choose_in};
      end
   end
   assign freq_sel_out = fsel_sync[1];
   assign phase_sel_out = psel_sync[1];

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   AST_VALID_PULSE: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      word_valid_out |=> !word_valid_out)
      else $error("word valid longer than one cycle");
   AST_PHASE_LOAD: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      (new_word && link_word[15:13] == 3'h6) |=> phase0_out == $past(link_word[11:0]))
      else $error("phase zero not loaded");
   AST_PHASE1_LOAD: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      (new_word && link_word[15:13] == 3'h7) |=> phase1_out == $past(link_word[11:0]))
      else $error("phase one not loaded");
   AST_PHASE_HOLD: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      (new_word && link_word[15:14] != 2'h3) |=> $stable(phase0_out) && $stable(phase1_out))
      else $error("phase changed by other word");
   AST_FSEL: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      $rose(fsel_sync[0]) |=> freq_sel_out)
      else $error("frequency select lag wrong");
   AST_WORD: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      new_word |=> word_out == $past(link_word) && word_valid_out)
      else $error("word not presented");
   AST_CNT_CLR: assert property (@(negedge shift_clk_in)
      frame_sync_n_in |-> bit_cnt == 4'h0)
      else $error("count not cleared outside frame");
   AST_PSEL: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      $fell(psel_sync[0]) |=> !phase_sel_out)
      else $error("phase select lag wrong");
   AST_PSEL_RISE: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      $rose(psel_sync[0]) |=> phase_sel_out)
      else $error("phase select rise lag wrong");
   AST_FSEL_FALL: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      $fell(fsel_sync[0]) |=> !freq_sel_out)
      else $error("frequency select fall lag wrong");
   // A pulse may only follow a toggle seen by the synchroniser
   AST_VALID_SRC: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      !new_word |=> !word_valid_out)
      else $error("word valid without a new word");
   // Fields land at their positions; the word stays put for many cycles
   AST_WORD_FIELDS: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      word_valid_out |-> word_out.ctrl == link_word[CTRL_MSB:CTRL_LSB]
         && word_out.addr == link_word[ADDR_MSB:ADDR_LSB]
         && word_out.data == link_word[DATA_MSB:0])
      else $error("word fields misplaced");
   // Reset leaves no pulse and clears both phase registers
   AST_RESET_CLEAR: assert property (@(posedge sys_clk_in)
      !rstn_in |=> !word_valid_out && phase0_out == PHASE_RESET && phase1_out == PHASE_RESET)
      else $error("reset left state behind");
   // A new word that is not a phase word leaves phase register one unchanged
   AST_PHASE_ONLY: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      (new_word && !is_phase_word(link_word)) |=> $stable(phase1_out))
      else $error("phase one changed by other word");
endmodule : dds_serial_write_port
`default_nettype wire

// file: tb/host_model.sv
/*
 Host serial master model: shift clock, frame sync and data.
 Assumes the bench calls send() hierarchically, one frame at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module host_model (
   output logic sck_out,
   output logic fs_n_out,
   output logic sd_out
);
   // -------------------------------------------
   // Frame driver
   // -------------------------------------------
   initial begin
      sck_out = 1'b1;
      fs_n_out = 1'b1;
      sd_out = 1'b0;
   end
   // Period 64 ns keeps the shift clock well under the ceiling
   task automatic send(input logic [15:0] w, input int n, input bit idle_hi, input bit split);
      fs_n_out = 1'b0;
      #20;
      for (int i = 0; i < n; i++) begin
         sck_out = 1'b1;
         sd_out = w[15-i];
         #32 sck_out = 1'b0;
         #32;
         if (split && i == 7) begin
            sck_out = 1'b1;
            #100;
         end
      end
      sck_out = idle_hi;
      fs_n_out = 1'b1;
      sd_out = ~sd_out; // Released line must not look held
      #40;
   endtask
endmodule // host_model
`default_nettype wire

// file: tb/dds_serial_write_port_tb_top.sv
/*
 Self-checking bench for the serial write port.
 Assumes host_model drives the link side.
*/
`timescale 1ns/1ps
`default_nettype none
module dds_serial_write_port_tb_top;
   import dds_serial_pkg::*;
   logic sys_clk_in = 0, rstn_in = 0, fsel = 0, psel = 0, vld, fo, po;
   wire logic sck, fs_n, sd;
   serial_word_t word;
   logic [11:0] p0, p1, e0 = 0, e1 = 0;
   int err_total = 0, checked = 0, got = 0, cyc = 0, seed = 32'h9b326368;
   always #2.5 sys_clk_in = ~sys_clk_in;
   host_model host (.sck_out(sck), .fs_n_out(fs_n), .sd_out(sd));
   dds_serial_write_port dut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .shift_clk_in(sck),
      .frame_sync_n_in(fs_n), .serial_data_in(sd), .freq_reg_choose_in(fsel),
      .phase_reg_choose_in(psel), .word_valid_out(vld), .word_out(word), .phase0_out(p0),
      .phase1_out(p1), .freq_sel_out(fo), .phase_sel_out(po));
   // Pulse counter and hang guard
   always @(posedge sys_clk_in) begin
      cyc <= cyc + 1;
      if (vld === 1'b1) got <= got + 1;
      if (cyc == 40000) begin
         err_total++;
         tally_and_finish();
      end
   end
   task automatic cmp_val(input logic [15:0] a, input logic [15:0] e, input string m);
      checked++;
      if (a !== e) begin
         err_total++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask
   task automatic cmp_bit(input logic a, input logic e, input string m);
      cmp_val({15'h0000, a}, {15'h0000, e}, m);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Random words with the shift clock idling low or high, paused mid-word or not, then a short frame
   initial begin
      logic [15:0] w;
      int g;
      int r;
      repeat (6) @(posedge sys_clk_in);
      rstn_in <= 1'b1;
      repeat (2) @(posedge sys_clk_in);
      for (int k = 0; k < 16; k++) begin
         w = 16'($random(seed));
         if (k % 3 == 0) w[15:14] = 2'h3;
         g = got;
         host.send(w, 16, k[0], k[1]);
         cmp_val(16'(got - g), 16'h0001, "pulse count");
         cmp_val(word, w, "word");
         if (w[15:14] == PHASE_CODE) begin
            if (w[13]) e1 = w[11:0];
            else e0 = w[11:0];
         end
         cmp_val({4'h0, p0}, {4'h0, e0}, "phase0");
         cmp_val({4'h0, p1}, {4'h0, e1}, "phase1");
         @(posedge sys_clk_in);
         r = $random(seed);
         fsel <= r[0];
         r = $random(seed);
         psel <= r[0];
         repeat (3) @(posedge sys_clk_in);
         #1;
         cmp_bit(fo, fsel, "freq select");
         cmp_bit(po, psel, "phase select");
         $display("test %0d done", k);
      end
      // Mid-run reset: word and both phase registers read back cleared
      @(posedge sys_clk_in);
      rstn_in <= 1'b0;
      repeat (2) @(posedge sys_clk_in);
      rstn_in <= 1'b1;
      e0 = 12'h000;
      e1 = 12'h000;
      w = 16'h0000;
      repeat (2) @(posedge sys_clk_in);
      #1;
      cmp_val(word, w, "reset word");
      cmp_val({4'h0, p0}, {4'h0, e0}, "reset phase0");
      cmp_val({4'h0, p1}, {4'h0, e1}, "reset phase1");
      $display("test mid reset done");
      g = got;
      host.send(16'hFFFF, 9, 1'b0, 1'b0);
      cmp_val(16'(got - g), 16'h0000, "short frame pulse");
      cmp_val(word, w, "short frame word");
      $display("test short frame done");
      tally_and_finish();
   end
endmodule // dds_serial_write_port_tb_top
`default_nettype wire
